// ==== design/lcf_filter.sv ====
// Loop compensator: PID stage, dither, low-pass or sinc second stage
// Operation
// [R1] PID then one selected second stage
// [R2] Output is P plus I plus D
// [R3] Proportional coef unsigned 2.4 format
// [R4] Integral coef seven bits, two implied zeros
// [R5] Writing clear bit zeroes the integrator
// [R6] Current limit with hold freezes integrator
// [R7] Integrator saturates, never wraps
// [R8] Derivative coef unsigned six-bit integer
// [R9] Low-pass gain(1+z-1)/(1+a1z-1+a2z-2)
// [R10] First pole signed 1.6 format
// [R11] Second pole unsigned seven-bit fraction
// [R12] Low-pass gain seven-bit fraction, live
// [R13] Low-pass output refreshed every sample
// [R14] Sinc gain(1-z-ratio)/(1-z-1), decimated
// [R15] Sinc gain eight-bit unsigned fraction
// [R16] Decimation ratio 1 to 256
// [R17] Sinc outputs window average of PID
// [R18] Sinc output handed over at cycle start
// [R19] Hold ends when limit events stop
// [R20] Dither added between PID and stage two
// [R21] Internal word is 22 bits
// [R22] Output msb readable at control bit0
// [R23] Select bit: 0 low-pass, 1 sinc
// [R24] Ratio register zero means 256
`default_nettype none

module lcf_filter
	import lcf_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [AW-1:0]     wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              sample_valid,
	input  wire logic signed [5:0] error_sample,
	input  wire logic              current_limit_event,
	input  wire logic              switching_cycle_end_event,
	input  wire logic              pwm_cycle_start,
	output logic      [CTRLW-1:0]  control_out,
	output logic                   control_valid
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clamp a wide value to the 22-bit word instead of wrapping
	function automatic logic signed [XW-1:0] sat_w(
		input logic signed [XW-1:0] v
	);
		logic signed [XW-1:0] hi;
		logic signed [XW-1:0] lo;
		hi = XW'(2**(W-1) - 1);
		lo = -XW'(2**(W-1));
		if (v > hi)
			sat_w = hi;
		else if (v < lo)
			sat_w = lo;
		else
			sat_w = v;
	endfunction

	// Integer part of the word, clamped to the unsigned control range
	function automatic logic [CTRLW-1:0] to_ctrl(
		input logic signed [XW-1:0] v
	);
		logic signed [XW-1:0] t;
		t = v >>> FRAC;
		if (t < 0)
			to_ctrl = '0;
		else if (t > XW'(2**CTRLW - 1))
			to_ctrl = '1;
		else
			to_ctrl = t[CTRLW-1:0];
	endfunction

	// ------------------------------------------------------------
	// Register file over classic Wishbone
	// ------------------------------------------------------------
	lcf_coef_t        coef_q;
	lcf_ctrl_t        ctrl_q;
	logic             clear_q;
	logic             wr_en;
	logic             req;

	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en = req && wb_we_i && wb_sel_i[0];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			coef_q  <= COEF_RST;
			ctrl_q  <= CTRL_RST;
			clear_q <= 1'b0;
		end
		else
		begin
			clear_q <= 1'b0;
			if (wr_en)
			begin
				case (wb_adr_i)
				OFS_PROP:  coef_q.kp <= wb_dat_i[5:0]; // [R3]
				OFS_INTG:
				begin
					coef_q.ki <= wb_dat_i[6:0]; // [R4]
					clear_q   <= wb_dat_i[CLEAR_BIT]; // [R5]
				end
				OFS_DERIV: coef_q.kd <= wb_dat_i[5:0]; // [R8]
				OFS_SINCG: coef_q.a0 <= wb_dat_i[7:0]; // [R15]
				OFS_POLE1: coef_q.a1 <= wb_dat_i[7:0]; // [R10]
				OFS_POLE2: coef_q.a2 <= wb_dat_i[6:0]; // [R11]
				OFS_LPG:   coef_q.a3 <= wb_dat_i[6:0]; // [R12]
				OFS_DEC:   coef_q.dec <= wb_dat_i[7:0]; // [R16]
				OFS_CTRL:
				begin
					ctrl_q.hold_en <= wb_dat_i[HOLD_BIT];
					ctrl_q.sel     <= wb_dat_i[SEL_BIT];
					ctrl_q.dither  <= wb_dat_i[DITH_LSB+2:DITH_LSB];
				end
				default: ;
				endcase
			end
		end
	end

	// Clear bit is a command: it always reads back as zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= '0;
		else if (req && !wb_we_i)
		begin
			case (wb_adr_i)
			OFS_PROP:  wb_dat_o <= {26'h0, coef_q.kp};
			OFS_INTG:  wb_dat_o <= {25'h0, coef_q.ki};
			OFS_DERIV: wb_dat_o <= {26'h0, coef_q.kd};
			OFS_SINCG: wb_dat_o <= {24'h0, coef_q.a0};
			OFS_POLE1: wb_dat_o <= {24'h0, coef_q.a1};
			OFS_POLE2: wb_dat_o <= {25'h0, coef_q.a2};
			OFS_LPG:   wb_dat_o <= {25'h0, coef_q.a3};
			OFS_DEC:   wb_dat_o <= {24'h0, coef_q.dec};
			OFS_CTRL:  wb_dat_o <= {24'h0, ctrl_q.hold_en, ctrl_q.sel,
				2'h0, ctrl_q.dither, control_out[CTRLW-1]}; // [R22]
			OFS_OUT:   wb_dat_o <= {24'h0, control_out[7:0]};
			default:   wb_dat_o <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Anti-windup hold
	// ------------------------------------------------------------
	logic hold_q;
	logic limit_seen_q;
	logic hold_now;

	assign hold_now = ctrl_q.hold_en && (hold_q || current_limit_event);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hold_q       <= 1'b0;
			limit_seen_q <= 1'b0;
		end
		else if (switching_cycle_end_event)
		begin
			// Release at any cycle end without a limit event on that same clock
			hold_q       <= current_limit_event; // [R19]
			limit_seen_q <= 1'b0;
		end
		else if (current_limit_event)
		begin
			hold_q       <= 1'b1; // [R6]
			limit_seen_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// PID stage
	// ------------------------------------------------------------
	logic signed [XW-1:0] e_x;
	logic signed [XW-1:0] eprev_x;
	logic signed [5:0]    eprev_q;
	logic signed [XW-1:0] acc_q;
	logic signed [XW-1:0] acc_upd;
	logic signed [XW-1:0] p_term;
	logic signed [XW-1:0] d_term;
	logic signed [XW-1:0] pid_sum;
	logic signed [XW-1:0] kp_x;
	logic signed [XW-1:0] ki_x;
	logic signed [XW-1:0] kd_x;

	assign e_x     = XW'(error_sample);
	assign eprev_x = XW'(eprev_q);
	assign kp_x    = XW'({1'b0, coef_q.kp});
	assign ki_x    = XW'({1'b0, coef_q.ki});
	assign kd_x    = XW'({1'b0, coef_q.kd});

	// Error scaled to the internal word: kp has 4 fraction bits
	assign p_term  = (e_x * kp_x) <<< (FRAC - 4); // [R3]
	// ki carries 9 fraction bits, matching the word directly
	assign acc_upd = sat_w(acc_q + e_x * ki_x); // [R4] [R7]
	assign d_term  = ((e_x - eprev_x) * kd_x) <<< FRAC; // [R8]
	assign pid_sum = sat_w(p_term + (hold_now ? acc_q : acc_upd)
		+ d_term); // [R2] [R21]

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_q <= '0;
		else if (clear_q)
			acc_q <= '0; // [R5]
		else if (sample_valid && !hold_now)
			acc_q <= acc_upd; // [R6] [R7]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			eprev_q <= '0;
		else if (sample_valid)
			eprev_q <= error_sample;
	end

	// ------------------------------------------------------------
	// Dither injection
	// ------------------------------------------------------------
	logic [15:0]          lfsr_q;
	logic signed [XW-1:0] dith;
	logic signed [XW-1:0] x_q;
	logic                 x_valid_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			lfsr_q <= LFSR_RST;
		else if (sample_valid)
			lfsr_q <= {lfsr_q[14:0],
				lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	// Amplitude codes 1..6 widen the noise; 0 and 7 disable it
	always_comb
	begin
		dith = '0;
		if (ctrl_q.dither != 3'h0 && ctrl_q.dither != 3'h7)
			dith = XW'($signed(lfsr_q[5:0])) <<< (ctrl_q.dither + 3'h1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			x_q       <= '0;
			x_valid_q <= 1'b0;
		end
		else
		begin
			x_valid_q <= sample_valid;
			if (sample_valid)
				x_q <= sat_w(pid_sum + dith); // [R20] [R1]
		end
	end

	// ------------------------------------------------------------
	// Two-pole low-pass stage
	// ------------------------------------------------------------
	logic signed [XW-1:0] x1_q;
	logic signed [XW-1:0] y1_q;
	logic signed [XW-1:0] y2_q;
	logic signed [XW-1:0] lp_acc;
	logic signed [XW-1:0] lp_y;

	// All products brought to 16 fraction bits before the sum
	assign lp_acc = XW'({1'b0, coef_q.a3}) * (x_q + x1_q)
		- ((XW'(coef_q.a1) * y1_q) <<< 1)
		- XW'({1'b0, coef_q.a2}) * y2_q; // [R9] [R12]
	assign lp_y = sat_w(lp_acc >>> 7); // [R21]

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			x1_q <= '0;
			y1_q <= '0;
			y2_q <= '0;
		end
		else if (x_valid_q)
		begin
			x1_q <= x_q;
			y1_q <= lp_y; // [R9]
			y2_q <= y1_q;
		end
	end

	// ------------------------------------------------------------
	// Sinc decimation stage
	// ------------------------------------------------------------
	logic [8:0]           ratio;
	logic [8:0]           cnt_q;
	logic signed [XW-1:0] sum_q;
	logic signed [XW-1:0] sum_all;
	logic signed [XW-1:0] sinc_q;

	assign ratio   = (coef_q.dec == 8'h00) ? RATIO_ZERO_AS
		: {1'b0, coef_q.dec}; // [R24] [R16]
	assign sum_all = sum_q + x_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q  <= '0;
			sum_q  <= '0;
			sinc_q <= '0;
		end
		else if (x_valid_q)
		begin
			if (cnt_q >= ratio - 9'h1)
			begin
				// Gain a0/256 scales the window sum; a0 of 256/ratio makes it an average
				sinc_q <= sat_w((sum_all * XW'({1'b0, coef_q.a0}))
					>>> 8); // [R14] [R15] [R17]
				sum_q  <= '0;
				cnt_q  <= '0;
			end
			else
			begin
				sum_q <= sum_all; // [R14]
				cnt_q <= cnt_q + 9'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Output select
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			control_out   <= '0;
			control_valid <= 1'b0;
		end
		else if (!ctrl_q.sel)
		begin
			control_valid <= x_valid_q;
			if (x_valid_q)
				control_out <= to_ctrl(lp_y); // [R13] [R23]
		end
		else
		begin
			// Held for the whole switching cycle to keep edges quiet
			control_valid <= pwm_cycle_start;
			if (pwm_cycle_start)
				control_out <= to_ctrl(sinc_q); // [R18] [R23]
		end
	end

endmodule

`default_nettype wire

// ==== design/lcf_pkg.sv ====
// Package for the loop compensator filter: register map, layouts, resets
`default_nettype none

package lcf_pkg;

	// ------------------------------------------------------------
	// Datapath format
	// ------------------------------------------------------------
	localparam int W     = 22;
	localparam int FRAC  = 9;
	localparam int XW    = 40;
	localparam int CTRLW = 9;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam int AW = 6;
	localparam logic [AW-1:0] OFS_PROP  = 6'h00;
	localparam logic [AW-1:0] OFS_INTG  = 6'h04;
	localparam logic [AW-1:0] OFS_DERIV = 6'h08;
	localparam logic [AW-1:0] OFS_SINCG = 6'h0c;
	localparam logic [AW-1:0] OFS_POLE1 = 6'h10;
	localparam logic [AW-1:0] OFS_POLE2 = 6'h14;
	localparam logic [AW-1:0] OFS_LPG   = 6'h18;
	localparam logic [AW-1:0] OFS_DEC   = 6'h1c;
	localparam logic [AW-1:0] OFS_CTRL  = 6'h20;
	localparam logic [AW-1:0] OFS_OUT   = 6'h24;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CLEAR_BIT = 7;
	localparam int HOLD_BIT  = 7;
	localparam int SEL_BIT   = 6;
	localparam int DITH_LSB  = 1;
	localparam int MSB_BIT   = 0;

	// ------------------------------------------------------------
	// Types and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0]        kp;
		logic [6:0]        ki;
		logic [5:0]        kd;
		logic [7:0]        a0;
		logic signed [7:0] a1;
		logic [6:0]        a2;
		logic [6:0]        a3;
		logic [7:0]        dec;
	} lcf_coef_t;

	typedef struct packed {
		logic       hold_en;
		logic       sel;
		logic [2:0] dither;
	} lcf_ctrl_t;

	localparam lcf_coef_t COEF_RST  = '0;
	localparam lcf_ctrl_t CTRL_RST  = '0;
	localparam logic [15:0] LFSR_RST = 16'hace1;
	localparam logic [8:0]  RATIO_ZERO_AS = 9'h100;

endpackage

`default_nettype wire

// ==== verification/lcf_far_end.sv ====
// Loop ADC sample source and PWM cycle source for the bench
`default_nettype none

module lcf_far_end
#(
	parameter int SP = 12,
	parameter int PP = 100
)
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic signed [5:0] err,
	output logic                   sample_valid,
	output logic signed [5:0]      error_sample,
	output logic                   pwm_cycle_start
);
	timeunit 1ns;
	timeprecision 1ps;

	int s_q;
	int p_q;

	// Off-sample the data line shows the inverse, never a stale copy
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			s_q <= 0;
			p_q <= 0;
			sample_valid <= 1'b0;
			error_sample <= 6'h0;
			pwm_cycle_start <= 1'b0;
		end
		else
		begin
			s_q <= (s_q == SP - 1) ? 0 : s_q + 1;
			p_q <= (p_q == PP - 1) ? 0 : p_q + 1;
			sample_valid <= (s_q == 0);
			error_sample <= (s_q == 0) ? err : ~err;
			pwm_cycle_start <= (p_q == 0);
		end
endmodule

`default_nettype wire

// ==== verification/lcf_filter_checker.sv ====
// Port checker for the loop compensator filter
`default_nettype none

module lcf_filter_checker
	import lcf_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [AW-1:0]     wb_adr_i,
	input wire logic [31:0]       wb_dat_i,
	input wire logic [3:0]        wb_sel_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              sample_valid,
	input wire logic signed [5:0] error_sample,
	input wire logic              current_limit_event,
	input wire logic              switching_cycle_end_event,
	input wire logic              pwm_cycle_start,
	input wire logic [CTRLW-1:0]  control_out,
	input wire logic              control_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("request not acked");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without request");
	rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read upper bits set");
	unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) > OFS_OUT |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	out_read_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == OFS_OUT
		|-> wb_dat_o[7:0] == $past(control_out[7:0]))
		else $error("output low byte wrong");
	msb_read_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == OFS_CTRL
		|-> wb_dat_o[MSB_BIT] == $past(control_out[CTRLW-1]))
		else $error("output msb wrong");
	out_change_a: assert property ($changed(control_out)
		|-> control_valid) else $error("silent output change");
	out_cause_a: assert property (control_valid
		|-> $past(sample_valid, 2) || $past(pwm_cycle_start))
		else $error("output update without cause");

	lp_cov: cover property (sample_valid ##2 control_valid);
	pwm_cov: cover property (pwm_cycle_start ##1 control_valid);
	rd_cov: cover property (wb_ack_o && !wb_we_i);
endmodule

bind lcf_filter lcf_filter_checker i_lcf_filter_checker (.clk(clk),
	.rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sample_valid(sample_valid), .error_sample(error_sample),
	.current_limit_event(current_limit_event),
	.switching_cycle_end_event(switching_cycle_end_event),
	.pwm_cycle_start(pwm_cycle_start), .control_out(control_out),
	.control_valid(control_valid));

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the loop compensator filter
`default_nettype none

module tb
	import lcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk = 1'b0, rst = 1'b1, cle = 1'b0, sce = 1'b0;
	logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic             ack, sv, pcs, cval;
	logic [AW-1:0]    adr = '0;
	logic [3:0]       sel = '0;
	logic [31:0]      dat = '0, rdat, q, x;
	logic signed [5:0] es, err = '0;
	logic [CTRLW-1:0] cout;
	logic [7:0]       msk [8] = '{8'h3f, 8'h7f, 8'h3f, 8'hff,
		8'hff, 8'h7f, 8'h7f, 8'hff};
	int               bad_count = 0, comparisons = 0, seed = 95305;
	int               kp, g, e;

	lcf_filter i_lcf_filter (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sample_valid(sv), .error_sample(es), .current_limit_event(cle),
		.switching_cycle_end_event(sce), .pwm_cycle_start(pcs),
		.control_out(cout), .control_valid(cval));
	lcf_far_end i_lcf_far_end (.clk(clk), .rst(rst), .err(err),
		.sample_valid(sv), .error_sample(es), .pwm_cycle_start(pcs));

	initial forever #4 clk = ~clk;

	task wb(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, 4'h1};
		while (ack !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		q = rdat;
		{cyc, stb} <= 2'b00;
		if (n >= 40)
			bad_count++;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task smp(input int n);
		repeat (n) @(posedge clk iff sv);
	endtask

	// Shift by sh then clamp to the unsigned 9-bit control range
	function automatic logic [31:0] ctl(longint v, int sh);
		v = v >>> sh;
		return (v < 0) ? 32'h0 : (v > 511) ? 32'h1ff : 32'(v);
	endfunction

	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#400000;
		bad_count++;
		stop_test();
	end

	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i <= 10; i++)
		begin
			wb(1'b0, 6'(4 * i), 8'h0);
			chk(q, 32'h0);
		end
		for (int i = 0; i < 8; i++)
		begin
			g = $random(seed);
			wb(1'b1, 6'(4 * i), 8'(g));
			wb(1'b0, 6'(4 * i), 8'h0);
			chk(q, {24'h0, 8'(g) & msk[i]});
		end
		$display("reset and register test done");
		wb(1'b1, OFS_INTG, 8'h80);
		wb(1'b1, OFS_POLE1, 8'h0);
		wb(1'b1, OFS_POLE2, 8'h0);
		wb(1'b1, OFS_CTRL, 8'h0);
		for (int i = 0; i < 6; i++)
		begin
			kp = i ? $random(seed) & 63 : 63;
			g = i ? $random(seed) & 127 : 127;
			e = (i == 1) ? -32 : i ? $random(seed) % 32 : 31;
			wb(1'b1, OFS_PROP, 8'(kp));
			wb(1'b1, OFS_LPG, 8'(g));
			wb(1'b1, OFS_DERIV, 8'($random(seed) & 63));
			err <= 6'(e);
			smp(6);
			x = ctl(longint'(g) * 64 * e * kp, 16);
			chk({23'h0, cout}, x);
			wb(1'b0, OFS_OUT, 8'h0);
			chk(q, {24'h0, x[7:0]});
			wb(1'b0, OFS_CTRL, 8'h0);
			chk(q & 32'h1, {31'h0, x[8]});
		end
		$display("low-pass test done");
		wb(1'b1, OFS_PROP, 8'h0);
		wb(1'b1, OFS_DERIV, 8'h0);
		wb(1'b1, OFS_INTG, 8'h7f);
		err <= 6'sd31;
		smp(800);
		chk({23'h0, cout}, 32'h1ff);
		err <= 6'sd0;
		wb(1'b1, OFS_INTG, 8'hff);
		smp(4);
		chk({23'h0, cout}, 32'h0);
		wb(1'b1, OFS_CTRL, 8'h80);
		cle <= 1'b1;
		err <= 6'sd31;
		smp(20);
		chk({23'h0, cout}, 32'h0);
		cle <= 1'b0;
		sce <= 1'b1;
		@(posedge clk);
		sce <= 1'b0;
		smp(20);
		chk({31'h0, cout > 0}, 32'h1);
		$display("integrator test done");
		wb(1'b1, OFS_INTG, 8'h80);
		wb(1'b1, OFS_PROP, 8'd63);
		wb(1'b1, OFS_CTRL, 8'h40);
		for (int i = 0; i < 2; i++)
		begin
			e = 1 + ($random(seed) & 15);
			g = i ? 1 : 64;
			wb(1'b1, OFS_DEC, i ? 8'h0 : 8'h4);
			wb(1'b1, OFS_SINCG, 8'(g));
			err <= 6'(e);
			smp(i ? 520 : 12);
			@(posedge clk iff cval);
			x = ctl(longint'(i ? 256 : 4) * g * e * 63 * 32, 17);
			chk({23'h0, cout}, x);
		end
		$display("sinc test done");
		stop_test();
	end
endmodule

`default_nettype wire
